// File: design/tfa_pkg.sv
// register map, field layout and state type for the timer flag block
package tfa_pkg;

  localparam int ADDR_W = 16;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CMP_ACT = 16'h1020;
  localparam logic [15:0] IDX_CAP_EDGE = 16'h1021;
  localparam logic [15:0] IDX_CH_EN = 16'h1022;
  localparam logic [15:0] IDX_CH_FLG = 16'h1023;
  localparam logic [15:0] IDX_EN_DIV = 16'h1024;
  localparam logic [15:0] IDX_EV_FLG = 16'h1025;
  localparam logic [15:0] IDX_ACC_CTL = 16'h1026;
  localparam logic [15:0] IDX_ACC_CNT = 16'h1027;

  // implemented bits
  localparam logic [7:0] CAP_EDGE_MASK = 8'h3F;
  localparam logic [7:0] ACC_CTL_MASK = 8'hF3;

  // field positions
  localparam int EN_DIV_EN_LO = 4;
  localparam int EN_DIV_PR_LO = 0;
  localparam int ACC_DIR_BIT = 7;
  localparam int ACC_EN_BIT = 6;
  localparam int ACC_MODE_BIT = 5;
  localparam int ACC_EDGE_BIT = 4;
  localparam int ACC_RATE_LO = 0;
  localparam int FLG2_LO = 4;
  localparam int EV_WRAP = 3;
  localparam int EV_RTI = 2;
  localparam int EV_AOV = 1;
  localparam int EV_AEDGE = 0;

  // timing counts in E cycles and the accumulator full value
  localparam logic [6:0] PR_LOCK_CYC = 7'h40;
  localparam logic [5:0] E64_TERM = 6'h3F;
  localparam logic [3:0] PRE_TERM1 = 4'h0;
  localparam logic [3:0] PRE_TERM4 = 4'h3;
  localparam logic [3:0] PRE_TERM8 = 4'h7;
  localparam logic [3:0] PRE_TERM16 = 4'hF;
  localparam logic [7:0] ACC_FULL = 8'hFF;

  typedef enum logic [1:0] {
    PIN_OFF = 2'h0,
    PIN_TOGGLE = 2'h1,
    PIN_LOW = 2'h2,
    PIN_HIGH = 2'h3
  } tfa_pin_act_e;

  typedef struct packed {
    logic [7:0] cmp_act;
    logic [7:0] cap_edge;
    logic [7:0] ch_en;
    logic [7:0] ch_flg;
    logic [3:0] ev_en;
    logic [1:0] pre_sel;
    logic pr_locked;
    logic [6:0] lock_cnt;
    logic [3:0] ev_flg;
    logic [7:0] acc_ctl;
    logic [7:0] acc_cnt;
    logic [3:0] pre_cnt;
    logic tick;
    logic [15:0] rti_div;
    logic [2:0] cap_s1;
    logic [2:0] cap_s2;
    logic [2:0] cap_prev;
    logic acc_s1;
    logic acc_s2;
    logic acc_prev;
    logic mode_s1;
    logic mode_s2;
    logic pin_dat;
    logic [3:0] oc_lvl;
    logic irq1;
    logic irq2;
    logic [7:0] rdata;
  } tfa_state_s;

  localparam tfa_state_s TFA_STATE_RST = '0;

endpackage : tfa_pkg

// File: design/tfa_top.sv
// timer flags, periodic interrupt and pulse accumulator behind apb
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tfa_top
  import tfa_pkg::*;
#(
  parameter int RTI_BASE_LOG2 = 13
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter core events
  input wire logic [4:0] compare_match,
  input wire logic counter_wrap,
  output logic timer_tick,
  // capture and compare pins
  input wire logic [2:0] capture_pin,
  output logic [3:0] compare_pin_out,
  output logic [3:0] compare_pin_oe,
  // shared accumulator pin
  input wire logic acc_input_pin_in,
  input wire logic acc_pin_data,
  output logic acc_input_pin_out,
  output logic acc_input_pin_oe,
  // mode strap and interrupts
  input wire logic special_mode,
  output logic irq_channel,
  output logic irq_second
);

  tfa_state_s q;
  tfa_state_s d;
  logic hit;
  logic wr;
  logic [15:0] idx;
  logic [7:0] wdat;
  logic [7:0] rval;
  logic [2:0] cap_evt;
  logic [3:0] oc_next;
  logic [3:0] pre_term;
  logic [15:0] rti_mask;
  logic rti_hit;
  logic acc_on;
  logic gated;
  logic acc_edge_select;
  logic a_rise;
  logic a_fall;
  logic acc_edge;
  logic acc_inc;
  logic acc_ovf;
  logic acc_wr;
  logic e64;
  logic irq1_src;
  logic irq2_src;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  assign idx = {2'h0, paddr[ADDR_W-1:2]};
  assign wdat = pwdata[7:0];
  assign wr = psel & penable & pwrite & hit & pstrb[0];
  assign acc_wr = wr && (idx == IDX_ACC_CNT);
  // answer in the access cycle; data was latched at setup
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign prdata = {24'h0, q.rdata};

  always_comb begin : decode
    hit = (paddr[1:0] == 2'h0);
    rval = 8'h00;
    case (idx)
      IDX_CMP_ACT: rval = q.cmp_act;
      IDX_CAP_EDGE: rval = q.cap_edge;
      IDX_CH_EN: rval = q.ch_en;
      IDX_CH_FLG: rval = q.ch_flg;
      IDX_EN_DIV: rval = {q.ev_en, 2'h0, q.pre_sel};
      IDX_EV_FLG: rval = {q.ev_flg, 4'h0};
      IDX_ACC_CTL: rval = q.acc_ctl;
      IDX_ACC_CNT: rval = q.acc_cnt;
      default: hit = 1'b0;
    endcase
    if (!hit) begin
      rval = 8'h00;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_cap
    logic rise;
    logic fall;
    assign rise = q.cap_s2[i] & ~q.cap_prev[i];
    assign fall = ~q.cap_s2[i] & q.cap_prev[i];
    assign cap_evt[i] = (q.cap_edge[2*i] & rise) | (q.cap_edge[2*i+1] & fall);
  end

  for (genvar k = 0; k < 4; k++) begin : g_cmp
    tfa_pin_act_e act;
    assign act = tfa_pin_act_e'(q.cmp_act[2*k+:2]);
    always_comb begin
      oc_next[k] = q.oc_lvl[k];
      if (compare_match[k]) begin
        case (act)
          PIN_TOGGLE: oc_next[k] = ~q.oc_lvl[k];
          PIN_LOW: oc_next[k] = 1'b0;
          PIN_HIGH: oc_next[k] = 1'b1;
          default: oc_next[k] = q.oc_lvl[k];
        endcase
      end
    end
    assign compare_pin_oe[k] = (act != PIN_OFF);
  end

  assign compare_pin_out = q.oc_lvl;
  assign timer_tick = q.tick;
  assign acc_input_pin_out = q.pin_dat;
  assign acc_input_pin_oe = q.acc_ctl[ACC_DIR_BIT];
  assign irq_channel = q.irq1;
  assign irq_second = q.irq2;

  assign rti_mask = 16'((32'h1 << (RTI_BASE_LOG2 + int'(q.acc_ctl[ACC_RATE_LO+:2]))) - 32'h1);
  // divider starts at zero, so a full period first
  assign rti_hit = ((q.rti_div & rti_mask) == rti_mask);
  assign e64 = (q.rti_div[5:0] == E64_TERM);

  assign acc_on = q.acc_ctl[ACC_EN_BIT];
  assign gated = q.acc_ctl[ACC_MODE_BIT];
  assign acc_edge_select = q.acc_ctl[ACC_EDGE_BIT];
  // pin level read whatever the direction
  assign a_rise = q.acc_s2 & ~q.acc_prev;
  assign a_fall = ~q.acc_s2 & q.acc_prev;
  // edge bit chooses edge or inhibit level
  assign acc_edge = acc_on & (acc_edge_select ? a_rise : a_fall);
  // gated count on E/64 while not inhibited
  assign acc_inc = acc_on & (gated ? (e64 & (q.acc_s2 != acc_edge_select)) : acc_edge);
  assign acc_ovf = acc_inc & (q.acc_cnt == ACC_FULL);

  assign irq1_src = |(q.ch_flg & q.ch_en);
  assign irq2_src = |(q.ev_flg & q.ev_en);

  always_comb begin : pre_decode
    case (q.pre_sel)
      2'h0: pre_term = PRE_TERM1;
      2'h1: pre_term = PRE_TERM4;
      2'h2: pre_term = PRE_TERM8;
      default: pre_term = PRE_TERM16;
    endcase
  end

  always_comb begin : next_state
    d = q;
    // two flops before any logic looks at a pin
    d.cap_s1 = capture_pin;
    d.cap_s2 = q.cap_s1;
    d.cap_prev = q.cap_s2;
    d.acc_s1 = acc_input_pin_in;
    d.acc_s2 = q.acc_s1;
    d.acc_prev = q.acc_s2;
    d.mode_s1 = special_mode;
    d.mode_s2 = q.mode_s1;
    d.pin_dat = acc_pin_data;
    d.rti_div = q.rti_div + 16'h1;
    d.oc_lvl = oc_next;
    if (psel && !penable) begin
      d.rdata = rval;
    end
    d.tick = (q.pre_cnt >= pre_term);
    d.pre_cnt = d.tick ? 4'h0 : q.pre_cnt + 4'h1;
    if (!q.pr_locked) begin
      d.lock_cnt = q.lock_cnt + 7'h1;
      if (q.lock_cnt == PR_LOCK_CYC - 7'h1) begin
        d.pr_locked = 1'b1;
      end
    end
    if (wr) begin
      case (idx)
        IDX_CMP_ACT: d.cmp_act = wdat;
        IDX_CAP_EDGE: d.cap_edge = wdat & CAP_EDGE_MASK;
        IDX_CH_EN: d.ch_en = wdat;
        IDX_EN_DIV: begin
          d.ev_en = wdat[EN_DIV_EN_LO+:4];
          // first write locks unless special mode
          if (!q.pr_locked || q.mode_s2) begin
            d.pre_sel = wdat[EN_DIV_PR_LO+:2];
          end
          d.pr_locked = 1'b1;
        end
        IDX_ACC_CTL: d.acc_ctl = wdat & ACC_CTL_MASK;
        default: d.acc_ctl = q.acc_ctl;
      endcase
    end
    if (acc_wr) begin
      d.acc_cnt = wdat;
    end else if (acc_inc) begin
      d.acc_cnt = q.acc_cnt + 8'h1;
    end
    // written ones clear, a new event wins
    d.ch_flg = q.ch_flg & ~((wr && idx == IDX_CH_FLG) ? wdat : 8'h00);
    d.ev_flg = q.ev_flg & ~((wr && idx == IDX_EV_FLG) ? wdat[FLG2_LO+:4] : 4'h0);
    // compare and capture events set flags
    d.ch_flg = d.ch_flg | {compare_match, cap_evt};
    d.ev_flg[EV_WRAP] = d.ev_flg[EV_WRAP] | counter_wrap;
    d.ev_flg[EV_RTI] = d.ev_flg[EV_RTI] | rti_hit;
    d.ev_flg[EV_AOV] = d.ev_flg[EV_AOV] | acc_ovf;
    d.ev_flg[EV_AEDGE] = d.ev_flg[EV_AEDGE] | acc_edge;
    d.irq1 = irq1_src;
    d.irq2 = irq2_src;
  end

  // all fields, capture edges included, reset to zero
  always_ff @(posedge pclk or negedge presetn) begin : regs
    if (!presetn) begin
      q <= TFA_STATE_RST;
    end else begin
      q <= d;
    end
  end

  cap_edge_a: assert property ((q.cap_s2[0] && !q.cap_prev[0] && q.cap_edge[0]) |=> q.ch_flg[0])
    else $error("rising capture edge did not set flag");

  cmp_flag_a: assert property (compare_match[4] |=> q.ch_flg[7])
    else $error("compare match did not set flag");

  w1c_keep_a: assert property ((wr && idx == IDX_CH_FLG && !wdat[1] && q.ch_flg[1]) |=> q.ch_flg[1])
    else $error("writing zero cleared a flag");

  w1c_clear_a: assert property ((wr && idx == IDX_CH_FLG && wdat[0] && !cap_evt[0]) |=> !q.ch_flg[0])
    else $error("writing one did not clear flag");

  irq_chan_a: assert property (##1 irq_channel == $past(irq1_src))
    else $error("channel request does not follow flags");

  irq_sec_a: assert property (##1 irq_second == $past(irq2_src))
    else $error("second request does not follow flags");

  pr_lock_a: assert property ((q.pr_locked && !q.mode_s2) |=> $stable(q.pre_sel))
    else $error("divider select changed after lock");

  wrap_flag_a: assert property (counter_wrap |=> q.ev_flg[EV_WRAP])
    else $error("counter wrap did not set flag");

  oc_toggle_a: assert property ((compare_match[0] && q.cmp_act[1:0] == PIN_TOGGLE)
    |=> compare_pin_out[0] != $past(compare_pin_out[0]))
    else $error("toggle action did not invert pin");

  acc_wrap_a: assert property ((acc_ovf && !acc_wr) |=> (q.ev_flg[EV_AOV] && q.acc_cnt == 8'h00))
    else $error("accumulator roll over missed");

  tick_div4_a: assert property ((timer_tick && q.pre_sel == 2'h1 && q.pr_locked && !q.mode_s2)
    |=> !timer_tick [*3] ##1 timer_tick)
    else $error("divide by four tick spacing wrong");

endmodule : tfa_top
`default_nettype wire

// File: verification/tfa_pins.sv
// pin-side model: capture inputs and the shared accumulator line
`timescale 1ns/1ps
`default_nettype none
module tfa_pins (
  // clock
  input wire logic pclk,
  // pins toward the block
  output logic [2:0] cap_q,
  output logic acc_q
);
  initial begin
    cap_q = 3'h0;
    acc_q = 1'b0;
  end
  // slow pins: give the synchroniser time to settle
  task automatic set_cap(input logic [2:0] v);
    @(posedge pclk) cap_q <= v;
    repeat (6) @(posedge pclk);
  endtask : set_cap
  task automatic set_acc(input logic v);
    @(posedge pclk) acc_q <= v;
    repeat (6) @(posedge pclk);
  endtask : set_acc
  task automatic acc_pulses(input int n);
    repeat (n) begin
      @(posedge pclk) acc_q <= ~acc_q;
      repeat (2) @(posedge pclk);
      acc_q <= ~acc_q;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : acc_pulses
endmodule : tfa_pins
`default_nettype wire

// File: verification/tfa_top_tb.sv
// self-checking bench for the timer flag block
`timescale 1ns/1ps
`default_nettype none
module tfa_top_tb;
  import tfa_pkg::*;
  // short periodic base keeps the run brief
  localparam int BASE = 4;
  logic pclk, presetn, psel, penable, pwrite, special_mode, acc_pin_data, counter_wrap, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, pv, v;
  logic [3:0] pstrb, cmp_out, cmp_oe;
  logic [4:0] compare_match;
  logic [2:0] cap;
  logic pready, pslverr, timer_tick, acc_out, acc_oe, acc_drv, irq1, irq2;
  int num_errors, samples_checked, n;
  time t0, t1;
  // shared line: block drives it when its direction bit is set
  wire acc_wire = acc_oe ? acc_out : acc_drv;

  tfa_top #(.RTI_BASE_LOG2(BASE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_match(compare_match), .counter_wrap(counter_wrap), .timer_tick(timer_tick),
    .capture_pin(cap), .compare_pin_out(cmp_out), .compare_pin_oe(cmp_oe), .acc_input_pin_in(acc_wire),
    .acc_pin_data(acc_pin_data), .acc_input_pin_out(acc_out), .acc_input_pin_oe(acc_oe),
    .special_mode(special_mode), .irq_channel(irq1), .irq_second(irq2));
  tfa_pins pins (.pclk(pclk), .cap_q(cap), .acc_q(acc_drv));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // byte address is four times the register index
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= idx << 2;
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rdchk

  task automatic gap(output int g);
    do @(posedge pclk); while (timer_tick !== 1'b1);
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (timer_tick !== 1'b1);
  endtask : gap

  // irq stays up until cleared, so clear and let it drop
  task automatic rti_rise();
    do @(posedge pclk); while (irq2 !== 1'b1);
    t1 = $time;
    apb(1'b1, IDX_EV_FLG, 8'h40);
    repeat (2) @(posedge pclk);
  endtask : rti_rise

  task automatic pulse_match();
    @(posedge pclk) compare_match <= 5'h1F;
    @(posedge pclk) compare_match <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask : pulse_match

  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, counter_wrap, special_mode, acc_pin_data} = 7'h00;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    compare_match = 5'h00;
    void'($urandom(35));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, IDX_EN_DIV, 8'h01);
    gap(n);
    gap(n);
    chk(n, 4);
    apb(1'b1, IDX_EN_DIV, 8'h03);
    rdchk(IDX_EN_DIV, 32'h01);
    rdchk(IDX_CAP_EDGE, 32'h00);
    apb(1'b0, 16'h1030, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("reset and divider lock done");
    special_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, IDX_EN_DIV, c[7:0]);
      gap(n);
      gap(n);
      chk(n, 32'h1 << (c + (c > 0)));
    end
    special_mode <= 1'b0;
    repeat (80) @(posedge pclk);
    apb(1'b1, IDX_EN_DIV, 8'h00);
    rdchk(IDX_EN_DIV, 32'h03);
    $display("divider codes done");
    v = {24'h0, 8'($urandom())};
    apb(1'b1, IDX_CH_EN, v[7:0]);
    apb(1'b1, IDX_CMP_ACT, 8'h1B);
    pulse_match();
    chk(cmp_out, 4'h5);
    pulse_match();
    chk({cmp_oe, cmp_out}, 8'h71);
    rdchk(IDX_CH_FLG, 32'hF8);
    chk(irq1, |(v[7:0] & 8'hF8));
    // low byte strobe off: the write must be dropped without error
    pstrb <= 4'hE;
    apb(1'b1, IDX_CH_EN, ~v[7:0]);
    pstrb <= 4'hF;
    chk({31'h0, err}, 32'h0);
    rdchk(IDX_CH_EN, v);
    apb(1'b1, IDX_CH_FLG, 8'h00);
    rdchk(IDX_CH_FLG, 32'hF8);
    apb(1'b1, IDX_CH_FLG, 8'h80);
    rdchk(IDX_CH_FLG, 32'h78);
    apb(1'b1, IDX_CH_FLG, 8'hFF);
    apb(1'b1, IDX_CAP_EDGE, 8'h1B);
    pins.set_cap(3'h7);
    rdchk(IDX_CH_FLG, 32'h05);
    apb(1'b1, IDX_CH_FLG, 8'hFF);
    pins.set_cap(3'h0);
    rdchk(IDX_CH_FLG, 32'h03);
    $display("compare and capture done");
    apb(1'b1, IDX_EN_DIV, 8'h80);
    @(posedge pclk) counter_wrap <= 1'b1;
    @(posedge pclk) counter_wrap <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(irq2, 1'b1);
    apb(1'b0, IDX_EV_FLG, 8'h00);
    chk(rd & 32'hB0, 32'h80);
    apb(1'b1, IDX_EV_FLG, 8'h80);
    repeat (3) @(posedge pclk);
    chk(irq2, 1'b0);
    apb(1'b1, IDX_ACC_CTL, 8'h50);
    apb(1'b1, IDX_ACC_CNT, 8'hFE);
    pins.acc_pulses(2);
    rdchk(IDX_ACC_CNT, 32'h00);
    apb(1'b0, IDX_EV_FLG, 8'h00);
    chk(rd & 32'h30, 32'h30);
    apb(1'b1, IDX_ACC_CTL, 8'h40);
    apb(1'b1, IDX_ACC_CNT, 8'h10);
    pins.acc_pulses(3);
    rdchk(IDX_ACC_CNT, 32'h13);
    apb(1'b1, IDX_ACC_CTL, 8'h60);
    pins.set_acc(1'b1);
    apb(1'b1, IDX_ACC_CNT, 8'h00);
    repeat (256) @(posedge pclk);
    apb(1'b0, IDX_ACC_CNT, 8'h00);
    chk({31'h0, rd[7:0] inside {8'h04, 8'h05}}, 32'h1);
    pins.set_acc(1'b0);
    apb(1'b0, IDX_ACC_CNT, 8'h00);
    pv = rd;
    repeat (200) @(posedge pclk);
    rdchk(IDX_ACC_CNT, pv);
    apb(1'b1, IDX_ACC_CTL, 8'hD0);
    apb(1'b1, IDX_ACC_CNT, 8'h00);
    repeat (2) begin
      repeat (4) @(posedge pclk) acc_pin_data <= ~acc_pin_data;
    end
    repeat (6) @(posedge pclk);
    rdchk(IDX_ACC_CNT, 32'h04);
    $display("accumulator done");
    apb(1'b1, IDX_EN_DIV, 8'h40);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, IDX_ACC_CTL, r[7:0]);
      rti_rise();
      rti_rise();
      t0 = t1;
      rti_rise();
      chk(32'((t1 - t0) / 8), 32'h1 << (BASE + r));
    end
    $display("periodic rates done");
    tally_and_finish();
  end
endmodule : tfa_top_tb
`default_nettype wire
